// [src/adc_control_sequencer_consts.vh]
// Constants for the converter control sequencer.
// Assumes one 100 MHz clock and a 32-bit AXI4-Lite bus.
//
// Notes on behaviour
// - Three select bits pick divider or RC clock
// - Bits 5:3 route channel 0..7
// - Start bit begins conversion, clears when done
// - Power bit enables converter; clear shuts off
// - Unimplemented control bits read zero
// - Format bit picks right or left justification
// - Config field decodes analog or digital pins
// - Config field picks reference sources
// - Reset forces all pins analog
// - Reset clears registers, aborts conversion
// - Sleep conversions only with RC clock
// - Completion loads result, clears busy, flags
// - Ten-bit successive approximation result
// - Clearing start aborts; wait two periods
// - Conversion takes twelve clock periods
`ifndef ADC_CONTROL_SEQUENCER_CONSTS_VH
`define ADC_CONTROL_SEQUENCER_CONSTS_VH

// ----------------------------------------
// Register word offsets (address bits 5:2)
// ----------------------------------------
`define OFS_CTRL_ZERO   4'h0
`define OFS_CTRL_ONE    4'h1
`define OFS_RES_HIGH    4'h2
`define OFS_RES_LOW     4'h3
`define OFS_INT_STATUS  4'h4
`define OFS_INT_MASK    4'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CZ_CLK_LO_HI    7
`define CZ_CLK_LO_LO    6
`define CZ_CHAN_HI      5
`define CZ_CHAN_LO      3
`define CZ_GO_BIT       2
`define CZ_POWER_BIT    0
`define CO_FORMAT_BIT   7
`define CO_CLK_HI_BIT   6
`define CO_PCFG_HI      3
`define CO_PCFG_LO      0
`define IS_DONE_BIT     0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CTRL_ZERO_RST   8'h00
`define CTRL_ONE_RST    8'h00
`define RESULT_RST      8'h00
`define CZ_WR_MASK      8'hF9
`define CO_WR_MASK      8'hCF

// ----------------------------------------
// Timing counts in conversion clock periods
// ----------------------------------------
`define CONV_PERIODS    4'd12
`define ABORT_PERIODS   4'd2
`define RESULT_BITS     4'd10

`endif

// [src/adc_control_sequencer.v]
// Converter control sequencer: registers, clock select,
// successive approximation sequencer, port decode.
// Assumes an analog front end driven by sar_code_o and
// a comparator and RC oscillator outside this clock.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_control_sequencer_consts.vh"
`default_nettype none

module adc_control_sequencer (
  // Clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Device state
  input  wire        sleep_i,
  // Analog side
  input  wire        rc_osc_i,
  input  wire        comparator_i,
  output reg  [9:0]  sar_code_o,
  output reg         sample_hold_o,
  output wire        power_o,
  output wire [2:0]  channel_o,
  output reg  [7:0]  analog_pins_o,
  output reg         vref_pos_ext_o,
  output reg         vref_neg_ext_o,
  // Interrupt
  output wire        irq_o
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_CONV  = 2'b01;
  localparam ST_ABORT = 2'b10;

  reg  [7:0] ctrl_zero_reg;
  reg  [7:0] ctrl_one_reg;
  reg  [7:0] res_high_reg;
  reg  [7:0] res_low_reg;
  reg        done_flag_reg;
  reg        done_mask_reg;
  reg  [1:0] state_reg;
  reg  [3:0] period_cnt_reg;
  reg  [5:0] div_cnt_reg;
  reg  [9:0] sar_reg;
  reg  [9:0] trial_reg;
  reg  [1:0] rc_sync_reg;
  reg        rc_prev_reg;
  reg  [1:0] cmp_sync_reg;
  reg  [3:0] aw_addr_reg;
  reg        aw_held_reg;
  reg  [7:0] w_data_reg;
  reg        w_strb_reg;
  reg        w_held_reg;

  wire [2:0] clk_code;
  wire       rc_sel;
  wire       rc_tick;
  reg  [5:0] div_limit;
  wire       osc_tick;
  wire       tad_tick;
  wire       wr_do;
  wire       wr_ok;
  wire       cmp_bit;
  wire       go_bit;
  wire       wr_zero;
  wire       conv_end;

  // ----------------------------------------
  // Conversion clock select
  // ----------------------------------------
  assign clk_code = {ctrl_one_reg[`CO_CLK_HI_BIT],
                     ctrl_zero_reg[`CZ_CLK_LO_HI:`CZ_CLK_LO_LO]};
  assign rc_sel   = (clk_code[1:0] == 2'b11);

  always @* begin
    case (clk_code)
      3'b000:  div_limit = 6'h01;
      3'b001:  div_limit = 6'h07;
      3'b010:  div_limit = 6'h1F;
      3'b100:  div_limit = 6'h03;
      3'b101:  div_limit = 6'h0F;
      3'b110:  div_limit = 6'h3F;
      default: div_limit = 6'h01;
    endcase
  end

  // Oscillator divider halts in sleep
  assign osc_tick = !sleep_i && (div_cnt_reg == div_limit);
  assign rc_tick  = rc_sync_reg[1] && !rc_prev_reg;
  assign tad_tick = (state_reg != ST_IDLE) &&
                    (rc_sel ? rc_tick : osc_tick);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_cnt_reg  <= 6'h00;
      rc_sync_reg  <= 2'b00;
      rc_prev_reg  <= 1'b0;
      cmp_sync_reg <= 2'b00;
    end else begin
      rc_sync_reg  <= {rc_sync_reg[0], rc_osc_i};
      rc_prev_reg  <= rc_sync_reg[1];
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_i};
      if (state_reg == ST_IDLE || rc_sel || osc_tick)
        div_cnt_reg <= 6'h00;
      else if (!sleep_i)
        div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  assign cmp_bit = cmp_sync_reg[1];

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok   = (aw_addr_reg <= `OFS_INT_MASK);
  assign wr_zero = wr_do && w_strb_reg &&
                   (aw_addr_reg == `OFS_CTRL_ZERO);
  assign go_bit  = w_data_reg[`CZ_GO_BIT];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 8'h00;
      w_strb_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= (s_axi_awaddr[31:6] == 26'h0) ?
                       s_axi_awaddr[5:2] : 4'hF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr[31:6] != 26'h0)
          s_axi_rresp <= 2'b10;
        else begin
          case (s_axi_araddr[5:2])
            `OFS_CTRL_ZERO: s_axi_rdata[7:0] <= ctrl_zero_reg;
            `OFS_CTRL_ONE: s_axi_rdata[7:0] <= ctrl_one_reg;
            `OFS_RES_HIGH: s_axi_rdata[7:0] <= res_high_reg;
            `OFS_RES_LOW: s_axi_rdata[7:0] <= res_low_reg;
            `OFS_INT_STATUS: s_axi_rdata[`IS_DONE_BIT] <= done_flag_reg;
            `OFS_INT_MASK: s_axi_rdata[`IS_DONE_BIT] <= done_mask_reg;
            default:
              s_axi_rresp <= 2'b10;
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  assign power_o   = ctrl_zero_reg[`CZ_POWER_BIT];
  assign channel_o = ctrl_zero_reg[`CZ_CHAN_HI:`CZ_CHAN_LO];
  assign conv_end  = (state_reg == ST_CONV) && tad_tick &&
                     (period_cnt_reg == `CONV_PERIODS - 4'd1);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_zero_reg  <= `CTRL_ZERO_RST;
      ctrl_one_reg   <= `CTRL_ONE_RST;
      res_high_reg   <= `RESULT_RST;
      res_low_reg    <= `RESULT_RST;
      done_flag_reg  <= 1'b0;
      done_mask_reg  <= 1'b0;
      state_reg      <= ST_IDLE;
      period_cnt_reg <= 4'h0;
      sar_reg        <= 10'h000;
      trial_reg      <= 10'h000;
      sar_code_o     <= 10'h000;
      sample_hold_o  <= 1'b0;
    end else begin
      // Register writes
      if (wr_do && w_strb_reg) begin
        case (aw_addr_reg)
          `OFS_CTRL_ZERO: begin
            ctrl_zero_reg[7:3] <= w_data_reg[7:3];
            ctrl_zero_reg[`CZ_POWER_BIT] <= w_data_reg[`CZ_POWER_BIT];
          end
          `OFS_CTRL_ONE: ctrl_one_reg <= w_data_reg & `CO_WR_MASK;
          `OFS_RES_HIGH: res_high_reg <= w_data_reg;
          `OFS_RES_LOW: res_low_reg <= w_data_reg;
          `OFS_INT_MASK: done_mask_reg <= w_data_reg[`IS_DONE_BIT];
          default: ;
        endcase
      end
      // Sticky flag, set wins over clear
      if (conv_end)
        done_flag_reg <= 1'b1;
      else if (wr_do && w_strb_reg &&
               aw_addr_reg == `OFS_INT_STATUS &&
               w_data_reg[`IS_DONE_BIT])
        done_flag_reg <= 1'b0;

      case (state_reg)
        ST_IDLE: begin
          sample_hold_o <= 1'b0;
          ctrl_zero_reg[`CZ_GO_BIT] <= 1'b0;
          if (wr_zero && go_bit &&
              ctrl_zero_reg[`CZ_POWER_BIT] &&
              w_data_reg[`CZ_POWER_BIT]) begin
            state_reg      <= ST_CONV;
            ctrl_zero_reg[`CZ_GO_BIT] <= 1'b1;
            period_cnt_reg <= 4'h0;
            sar_reg        <= 10'h000;
            trial_reg      <= 10'h200;
            sar_code_o     <= 10'h200;
            sample_hold_o  <= 1'b1;
          end
        end
        ST_CONV: begin
          if (wr_zero && (!go_bit ||
              !w_data_reg[`CZ_POWER_BIT])) begin
            state_reg      <= ST_ABORT;
            ctrl_zero_reg[`CZ_GO_BIT] <= 1'b0;
            period_cnt_reg <= 4'h0;
            sample_hold_o  <= 1'b0;
          end else if (tad_tick) begin
            period_cnt_reg <= period_cnt_reg + 4'd1;
            if (period_cnt_reg < `RESULT_BITS) begin
              sar_reg    <= sar_reg |
                            (cmp_bit ? trial_reg : 10'h000);
              sar_code_o <= (sar_reg |
                            (cmp_bit ? trial_reg : 10'h000)) |
                            (trial_reg >> 1);
              trial_reg  <= trial_reg >> 1;
            end
            if (conv_end) begin
              state_reg     <= ST_IDLE;
              sample_hold_o <= 1'b0;
              ctrl_zero_reg[`CZ_GO_BIT] <= 1'b0;
              if (ctrl_one_reg[`CO_FORMAT_BIT]) begin
                res_high_reg <= {6'h00, sar_reg[9:8]};
                res_low_reg  <= sar_reg[7:0];
              end else begin
                res_high_reg <= sar_reg[9:2];
                res_low_reg  <= {sar_reg[1:0], 6'h00};
              end
            end
          end
        end
        ST_ABORT: begin
          ctrl_zero_reg[`CZ_GO_BIT] <= 1'b0;
          if (tad_tick) begin
            period_cnt_reg <= period_cnt_reg + 4'd1;
            if (period_cnt_reg == `ABORT_PERIODS - 4'd1)
              state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Port configuration decode
  // ----------------------------------------
  // Pin mask, then positive and negative external reference
  always @* begin
    case (ctrl_one_reg[`CO_PCFG_HI:`CO_PCFG_LO])
      4'h0: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'hFF, 2'h0};
      4'h1: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'hF7, 2'h2};
      4'h2: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h1F, 2'h0};
      4'h3: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h17, 2'h2};
      4'h4: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h0B, 2'h0};
      4'h5: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h03, 2'h2};
      4'h8: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'hF3, 2'h3};
      4'h9: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h3F, 2'h0};
      4'hA: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h37, 2'h2};
      4'hB: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h33, 2'h3};
      4'hC: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h13, 2'h3};
      4'hD: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h03, 2'h3};
      4'hE: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h01, 2'h0};
      4'hF: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = {8'h01, 2'h3};
      default: {analog_pins_o, vref_pos_ext_o, vref_neg_ext_o} = 10'h000;
    endcase
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign irq_o = done_flag_reg && done_mask_reg;

endmodule

`default_nettype wire

// [testbench/adc_control_sequencer_monitor.sv]
// Port checker for the converter control sequencer.
// Assumes a bind onto adc_control_sequencer, one clock.
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Bus answers
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Converter side
  input wire logic [9:0]  sar_code_o,
  input wire logic        sample_hold_o,
  input wire logic        power_o,
  input wire logic [7:0]  analog_pins_o,
  input wire logic        vref_pos_ext_o,
  input wire logic        vref_neg_ext_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reset_state: assert property ($fell(sys_rst_i) |->
    analog_pins_o == 8'hFF && !power_o && !irq_o)
    else $error("state after reset wrong");
  a_power_off_idle: assert property (!power_o [*2] |-> !sample_hold_o)
    else $error("conversion while powered off");
  a_first_trial: assert property ($rose(sample_hold_o) |->
    sar_code_o == 10'h200)
    else $error("first trial code wrong");
  a_conv_bounded: assert property ($rose(sample_hold_o) |->
    ##[1:1000] !sample_hold_o)
    else $error("conversion never ends");
  a_ref_pair: assert property (vref_neg_ext_o |-> vref_pos_ext_o)
    else $error("negative reference without positive");
  a_ref_pin: assert property (vref_pos_ext_o |-> !analog_pins_o[3])
    else $error("reference pin also analog input");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready)
    else $error("read answer dropped early");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  c_conv: cover property ($rose(sample_hold_o));
  c_irq: cover property ($rose(irq_o));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind adc_control_sequencer adc_control_sequencer_monitor mon_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .sar_code_o(sar_code_o),
  .sample_hold_o(sample_hold_o), .power_o(power_o),
  .analog_pins_o(analog_pins_o), .vref_pos_ext_o(vref_pos_ext_o),
  .vref_neg_ext_o(vref_neg_ext_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/adc_front_model.sv]
// Analog front end model: comparator and RC oscillator.
// Assumes the sequencer synchronises both inputs.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model #(
  parameter int RC_HALF_NS = 47
) (
  // Held level and trial code
  input  wire logic [9:0] level_i,
  input  wire logic [9:0] sar_code_i,
  // Front end outputs
  output var  logic       rc_osc_o,
  output wire logic       comparator_o
);
  // RC clock runs free, also in sleep
  initial begin
    rc_osc_o = 1'b0;
    forever #(RC_HALF_NS) rc_osc_o = ~rc_osc_o;
  end
  // High while level at or above trial code
  assign comparator_o = (level_i >= sar_code_i);
endmodule
`default_nettype wire

// [testbench/adc_control_sequencer_tb_top.sv]
// Self-checking bench for the converter control sequencer.
// Assumes the front end model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer_tb_top;
  logic        clk_i, sys_rst_i = 1'b1, sleep_i = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, d;
  logic        awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [1:0]  r;
  logic [9:0]  level = 10'h2A5;
  wire         awready, wready, bvalid, arready, rvalid, rc, cmp;
  wire         sh, power_o, vpos, vneg, irq_o;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [9:0]  sar;
  wire  [2:0]  chan;
  wire  [7:0]  pins;
  int          miscompares = 0, num_checks = 0, hi_cnt = 0;
  // Address, write value, read value, response
  logic [31:0] rows [8] = '{32'h00FFF900, 32'h00000000,
    32'h04FFCF00, 32'h04000000, 32'h085A5A00,
    32'h0CA5A500, 32'h14010100, 32'h18010002};
  // Analog pins, positive and negative reference per code
  logic [9:0]  pcfg_tab [16] = '{10'h3FC, 10'h3DE, 10'h07C,
    10'h05E, 10'h02C, 10'h00E, 10'h000, 10'h000, 10'h3CF,
    10'h0FC, 10'h0DE, 10'h0CF, 10'h04F, 10'h00F, 10'h004, 10'h007};
  logic [2:0]  ck_code [6] = '{3'd0, 3'd1, 3'd2, 3'd4, 3'd5, 3'd6};
  int          ck_div [6] = '{2, 8, 32, 4, 16, 64};

  adc_control_sequencer dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_i(sleep_i), .rc_osc_i(rc), .comparator_i(cmp),
    .sar_code_o(sar), .sample_hold_o(sh), .power_o(power_o),
    .channel_o(chan), .analog_pins_o(pins), .vref_pos_ext_o(vpos),
    .vref_neg_ext_o(vneg), .irq_o(irq_o));
  adc_front_model front_u (.level_i(level), .sar_code_i(sar),
    .rc_osc_o(rc), .comparator_o(cmp));

  // ----------------------------------------
  // Clock, conversion length, watchdog
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sh) hi_cnt <= hi_cnt + 1;
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic conv(input logic [7:0] c0);
    wr(32'h0, c0);
    wr(32'h0, c0 | 8'h04);
    rd(32'h0);
    chk(d[2], 1'b1);
    do rd(32'h0); while (d[2] === 1'b1);
  endtask
  task automatic do_reset;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset;
    @(posedge clk_i);
    chk(pins, 8'hFF);
    rd(32'h4);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      chk(r, rows[i][1:0]);
      rd(rows[i][31:24]);
      chk(d, rows[i][15:8]);
      chk(r, rows[i][1:0]);
    end
    $display("register test done");
    // Channels 0 to 7 all exist on this variant
    for (int i = 0; i < 16; i++) begin
      wr(32'h4, 8'(i));
      wr(32'h0, 8'(i << 3));
      chk({pins, vpos, vneg}, pcfg_tab[i]);
      chk(chan, i[2:0]);
    end
    $display("decode test done");
    for (int i = 0; i < 6; i++) begin
      wr(32'h4, {1'b1, ck_code[i][2], 6'h00});
      hi_cnt = 0;
      conv({ck_code[i][1:0], 6'h11});
      chk(hi_cnt, 12 * ck_div[i]);
      wr(32'h10, 8'h01);
    end
    conv(8'h91);
    chk(irq_o, 1'b1);
    rd(32'h8);
    chk(d, 32'h02);
    rd(32'hC);
    chk(d, 32'hA5);
    wr(32'h10, 8'h01);
    chk(irq_o, 1'b0);
    wr(32'h4, 8'h40);
    conv(8'h51);
    rd(32'h8);
    chk(d, 32'hA9);
    rd(32'hC);
    chk(d, 32'h40);
    wr(32'h10, 8'h01);
    $display("conversion test done");
    wr(32'h8, 8'h33);
    wr(32'h4, 8'hC0);
    wr(32'h0, 8'h95);
    repeat (40) @(posedge clk_i);
    wr(32'h0, 8'h91);
    wr(32'h0, 8'h95);
    rd(32'h0);
    chk(d, 32'h91);
    repeat (200) @(posedge clk_i);
    rd(32'h8);
    chk(d, 32'h33);
    chk(irq_o, 1'b0);
    $display("abort test done");
    wr(32'h4, 8'h80);
    sleep_i <= 1'b1;
    conv(8'hD1);
    sleep_i <= 1'b0;
    chk(irq_o, 1'b1);
    rd(32'hC);
    chk(d, 32'hA5);
    wr(32'h10, 8'h01);
    wr(32'h0, 8'h11);
    sleep_i <= 1'b1;
    wr(32'h0, 8'h15);
    repeat (100) @(posedge clk_i);
    rd(32'h0);
    chk(d[2], 1'b1);
    sleep_i <= 1'b0;
    do rd(32'h0); while (d[2] === 1'b1);
    chk(irq_o, 1'b1);
    $display("sleep test done");
    wr(32'h4, 8'hCF);
    wr(32'h0, 8'h95);
    repeat (20) @(posedge clk_i);
    do_reset;
    @(posedge clk_i);
    chk({power_o, sh, irq_o, pins}, 11'h0FF);
    rd(32'h0);
    chk(d, 32'h0);
    $display("reset test done");
    give_verdict;
  end
endmodule
`default_nettype wire
